// *** rtl/hpq_ctrl.sv ***
`timescale 1ns/1ps
module hpq_ctrl #(
   parameter int BUF_DEPTH = 2
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic [2:0]           reg_addr,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [15:0]          reg_wdata,
   output logic [15:0]               reg_rdata,
   input  wire hpq_pkg::hpq_tx_in_t  tx_in,
   input  wire logic                 tx_in_valid,
   output logic                      tx_in_ready,
   output hpq_pkg::hpq_tx_out_t      tx_out,
   output logic                      tx_out_valid,
   input  wire logic                 tx_out_ready,
   input  wire hpq_pkg::hpq_rx_beat_t rx_beat,
   input  wire logic                 rx_beat_valid,
   input  wire logic [47:0]          station_addr,
   input  wire logic                 rx_hash_hit,
   output hpq_pkg::hpq_verdict_t     rx_verdict,
   output logic                      rx_verdict_valid,
   input  wire logic                 rx_pause_rcvd,
   input  wire logic [15:0]          rx_pause_quanta,
   input  wire logic                 rx_fifo_at_thresh,
   input  wire logic                 sw_fc_en,
   output logic                      tx_pause_send
);
   import hpq_pkg::*;

   localparam int PW   = $clog2(BUF_DEPTH);
   localparam int PT_W = 16 + $clog2(QUANTUM_CYC) + 1;
   localparam logic [CNT_W-1:0] PAD_LAST = CNT_W'(PAD_LEN - 1);
   localparam logic [CNT_W-1:0] PAD_FULL = CNT_W'(PAD_LEN);
   localparam logic [CNT_W-1:0] MIN_LAST = CNT_W'(MIN_FRAME_LEN - 1);
   localparam logic [2:0]       ADDR_CNT = 3'(ADDR_LEN);

   generate
      if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
         $error("BUF_DEPTH must be a power of two, at least 2");
      end
   endgenerate

   // ***************************************************
   // register port
   // ***************************************************
   logic [15:0]      txc_reg;
   logic [15:0]      rxc_reg;
   logic [TAG_W-1:0] tx_tag_reg;
   logic [15:0]      reg_rdata_reg;

   // only writable bits are stored, so reserved ones stay zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         txc_reg <= REG_RST;
         rxc_reg <= REG_RST;
      end else if (reg_wr) begin
         if (reg_addr == TXC_OFS) txc_reg <= reg_wdata & TXC_RW_MASK;
         if (reg_addr == RXC_OFS) rxc_reg <= reg_wdata & RXC_RW_MASK;
      end
   end

   // read data is registered; unmapped offsets read zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata_reg <= REG_RST;
      end else if (reg_rd) begin
         unique case (reg_addr)
            TXC_OFS: reg_rdata_reg <= txc_reg;
            TXS_OFS: reg_rdata_reg <= 16'(tx_tag_reg);
            RXC_OFS: reg_rdata_reg <= rxc_reg;
            default: reg_rdata_reg <= REG_RST;
         endcase
      end
   end
   assign reg_rdata = reg_rdata_reg;

   // ***************************************************
   // transmit input buffer
   // ***************************************************
   hpq_tx_in_t  buf_mem [BUF_DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0]   cnt_reg;
   logic [PW:0]   cnt_next;
   logic          in_ready_reg;
   logic          buf_wr;
   logic          buf_pop;
   logic          buf_valid;
   hpq_tx_in_t    head;

   assign buf_wr    = tx_in_valid && in_ready_reg;
   assign buf_valid = (cnt_reg != '0);
   assign head      = buf_mem[rd_ptr_reg];
   assign cnt_next  = cnt_reg + (PW+1)'(buf_wr) - (PW+1)'(buf_pop);

   always_ff @(posedge core_clk) begin
      if (buf_wr) buf_mem[wr_ptr_reg] <= tx_in;
   end

   // ready is a flop fed from the next count: it drops on the same edge that fills the buffer
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_ptr_reg   <= '0;
         rd_ptr_reg   <= '0;
         cnt_reg      <= '0;
         in_ready_reg <= 1'b0;
      end else begin
         if (buf_wr) wr_ptr_reg <= wr_ptr_reg + PW'(1);
         if (buf_pop) rd_ptr_reg <= rd_ptr_reg + PW'(1);
         cnt_reg      <= cnt_next;
         in_ready_reg <= (cnt_next != (PW+1)'(BUF_DEPTH));
      end
   end
   assign tx_in_ready = in_ready_reg;

   // ***************************************************
   // transmit sequencer
   // ***************************************************
   hpq_tx_state_t    st_reg;
   hpq_tx_state_t    st_next;
   logic [CNT_W-1:0] cnt_b_reg;
   logic [31:0]      crc_reg;
   logic [1:0]       fcs_idx_reg;
   logic             fr_pad_reg;
   logic             fr_crc_reg;
   logic [TAG_W-1:0] cur_tag_reg;
   hpq_tx_out_t      tx_out_reg;
   logic             tx_out_valid_reg;
   logic [PT_W-1:0]  pause_tmr_reg;
   logic             pause_active;
   logic             adv;
   logic             emit;
   logic             emit_last;
   logic             finish;
   logic [7:0]       emit_d;

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      return r;
   endfunction : crc_byte

   assign adv          = !tx_out_valid_reg || tx_out_ready;
   assign pause_active = (pause_tmr_reg != '0);

   // next state and the byte offered to the output stage
   always_comb begin
      st_next   = st_reg;
      buf_pop   = 1'b0;
      emit      = 1'b0;
      emit_last = 1'b0;
      finish    = 1'b0;
      emit_d    = 8'h00;
      unique case (st_reg)
         TX_IDLE: begin
            // a new frame only starts while running and not paused
            if (txc_reg[TXC_RUN] && !pause_active && buf_valid) st_next = TX_DATA;
         end
         TX_DATA: begin
            if (adv && buf_valid) begin
               buf_pop = 1'b1;
               emit    = 1'b1;
               emit_d  = head.data;
               if (head.last) begin
                  if (fr_pad_reg && cnt_b_reg < PAD_LAST) st_next = TX_PAD;
                  else if (fr_crc_reg) st_next = TX_FCS;
                  else begin
                     emit_last = 1'b1;
                     finish    = 1'b1;
                     st_next   = TX_IDLE;
                  end
               end
            end
         end
         TX_PAD: begin
            if (adv) begin
               emit = 1'b1;
               if (cnt_b_reg == PAD_LAST) begin
                  if (fr_crc_reg) st_next = TX_FCS;
                  else begin
                     emit_last = 1'b1;
                     finish    = 1'b1;
                     st_next   = TX_IDLE;
                  end
               end
            end
         end
         TX_FCS: begin
            if (adv) begin
               emit   = 1'b1;
               emit_d = ~crc_reg[7:0];
               if (fcs_idx_reg == 2'h3) begin
                  emit_last = 1'b1;
                  finish    = 1'b1;
                  st_next   = TX_IDLE;
               end
            end
         end
      endcase
   end

   // per-frame settings are frozen at the start so a write mid-frame is harmless
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_reg      <= TX_IDLE;
         fr_pad_reg  <= 1'b0;
         fr_crc_reg  <= 1'b0;
         cur_tag_reg <= '0;
      end else begin
         st_reg <= st_next;
         if (st_reg == TX_IDLE && st_next == TX_DATA) begin
            fr_pad_reg  <= txc_reg[TXC_PAD];
            fr_crc_reg  <= txc_reg[TXC_CRC];
            cur_tag_reg <= head.tag;
         end
      end
   end

   // byte count saturates once the pad length is reached
   always_ff @(posedge core_clk) begin
      if (!rst_n || st_reg == TX_IDLE) begin
         cnt_b_reg   <= '0;
         crc_reg     <= CRC_INIT;
         fcs_idx_reg <= 2'h0;
      end else if (emit) begin
         if (cnt_b_reg != PAD_FULL) cnt_b_reg <= cnt_b_reg + CNT_W'(1);
         if (st_reg == TX_FCS) begin
            crc_reg     <= crc_reg >> 8;
            fcs_idx_reg <= fcs_idx_reg + 2'h1;
         end else begin
            crc_reg <= crc_byte(crc_reg, emit_d);
         end
      end
   end

   // output register, held until the receiver takes it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tx_out_reg       <= '0;
         tx_out_valid_reg <= 1'b0;
      end else if (emit) begin
         tx_out_reg       <= '{data: emit_d, last: emit_last};
         tx_out_valid_reg <= 1'b1;
      end else if (tx_out_ready) begin
         tx_out_valid_reg <= 1'b0;
      end
   end
   assign tx_out       = tx_out_reg;
   assign tx_out_valid = tx_out_valid_reg;

   // status belongs to the frame just completed
   always_ff @(posedge core_clk) begin
      if (!rst_n) tx_tag_reg <= '0;
      else if (finish) tx_tag_reg <= cur_tag_reg;
   end

   // ***************************************************
   // flow control
   // ***************************************************
   // a zero quanta pause cancels a running pause
   always_ff @(posedge core_clk) begin
      if (!rst_n || !rxc_reg[RXC_PHONOR]) pause_tmr_reg <= '0;
      else if (rx_pause_rcvd) pause_tmr_reg <= PT_W'(rx_pause_quanta) * PT_W'(QUANTUM_CYC);
      else if (pause_active) pause_tmr_reg <= pause_tmr_reg - PT_W'(1);
   end

   logic tx_pause_send_reg;
   // the switch-wide enable gates generation as well
   always_ff @(posedge core_clk) begin
      if (!rst_n) tx_pause_send_reg <= 1'b0;
      else tx_pause_send_reg <= txc_reg[TXC_PGEN] && sw_fc_en && rx_fifo_at_thresh;
   end
   assign tx_pause_send = tx_pause_send_reg;

   // ***************************************************
   // receive filter
   // ***************************************************
   logic         in_frame_reg;
   logic         live_reg;
   logic [2:0]   idx_reg;
   logic [47:0]  dst_reg;
   logic         live_now;
   logic         is_mcast;
   logic         is_bcast;
   logic         addr_ok;
   hpq_verdict_t verdict_reg;
   logic         verdict_valid_reg;

   assign live_now = in_frame_reg ? live_reg : rxc_reg[RXC_RUN];
   assign is_mcast = dst_reg[40];
   assign is_bcast = (dst_reg == BCAST_ADDR);
   assign addr_ok  = rxc_reg[RXC_PROMISC]
                  || (rxc_reg[RXC_BCAST] && is_bcast)
                  || (rxc_reg[RXC_MCAST] && is_mcast)
                  || (rxc_reg[RXC_HASH] && is_mcast && rx_hash_hit)
                  || (rxc_reg[RXC_UCAST] && !is_mcast && dst_reg == station_addr);

   // destination is gathered from the first six bytes, first octet on top
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         in_frame_reg <= 1'b0;
         live_reg     <= 1'b0;
         idx_reg      <= 3'h0;
         dst_reg      <= '0;
      end else if (rx_beat_valid) begin
         in_frame_reg <= !rx_beat.last;
         live_reg     <= live_now;
         if (idx_reg != ADDR_CNT) dst_reg <= {dst_reg[39:0], rx_beat.data};
         if (rx_beat.last) idx_reg <= 3'h0;
         else if (idx_reg != ADDR_CNT) idx_reg <= idx_reg + 3'h1;
      end
   end

   // one verdict per frame started while running
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         verdict_reg       <= '0;
         verdict_valid_reg <= 1'b0;
      end else begin
         verdict_valid_reg <= rx_beat_valid && rx_beat.last && live_now;
         if (rx_beat_valid && rx_beat.last) begin
            verdict_reg.accept   <= addr_ok && (!rx_beat.crc_err || rxc_reg[RXC_BADCRC]);
            verdict_reg.keep_crc <= !rxc_reg[RXC_CRCDROP];
         end
      end
   end
   assign rx_verdict       = verdict_reg;
   assign rx_verdict_valid = verdict_valid_reg;

   // ***************************************************
   // checks
   // ***************************************************
   logic [CNT_W-1:0] ob_cnt_reg;
   logic             rx_end;
   assign rx_end = rx_beat_valid && rx_beat.last;
   always_ff @(posedge core_clk) begin
      if (!rst_n || finish) ob_cnt_reg <= '0;
      else if (emit && ob_cnt_reg != '1) ob_cnt_reg <= ob_cnt_reg + CNT_W'(1);
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   pause_gen_a: assert property (txc_reg[TXC_PGEN] && sw_fc_en && rx_fifo_at_thresh |=> tx_pause_send)
      else $error("pause request not raised");
   pad_min_a: assert property (finish && fr_pad_reg && fr_crc_reg |-> ob_cnt_reg >= MIN_LAST)
      else $error("padded frame too short");
   crc_tail_a: assert property (finish && fr_crc_reg |-> st_reg == TX_FCS && fcs_idx_reg == 2'h3)
      else $error("checksum tail broken");
   fcs_len_a: assert property (st_reg == TX_FCS && !(emit && fcs_idx_reg == 2'h3) |=> st_reg == TX_FCS)
      else $error("checksum length wrong");
   tx_stop_a: assert property (st_reg == TX_IDLE && !txc_reg[TXC_RUN] |=> st_reg == TX_IDLE)
      else $error("frame started while stopped");
   tag_upd_a: assert property (finish |=> tx_tag_reg == $past(cur_tag_reg))
      else $error("status tag not updated");
   pause_hold_a: assert property (pause_active && st_reg == TX_IDLE |=> st_reg == TX_IDLE)
      else $error("frame sent during pause");
   pause_off_a: assert property (!rxc_reg[RXC_PHONOR] |=> !pause_active)
      else $error("pause honoured while disabled");
   bad_crc_a: assert property (rx_end && rx_beat.crc_err && !rxc_reg[RXC_BADCRC] |=> !rx_verdict.accept)
      else $error("crc error frame accepted");
   bcast_acc_a: assert property (rx_end && live_now && !rx_beat.crc_err && is_bcast
                                 && (rxc_reg[RXC_BCAST] || rxc_reg[RXC_MCAST]) |=> rx_verdict.accept)
      else $error("broadcast refused");
   promisc_a: assert property (rx_end && live_now && !rx_beat.crc_err && rxc_reg[RXC_PROMISC]
                               |=> rx_verdict_valid && rx_verdict.accept)
      else $error("promiscuous frame refused");
   strip_a: assert property (rx_verdict_valid |-> rx_verdict.keep_crc == !$past(rxc_reg[RXC_CRCDROP]))
      else $error("crc keep flag wrong");
   rx_stop_a: assert property (rx_end && !live_now |=> !rx_verdict_valid)
      else $error("verdict for stopped frame");
   resv_zero_a: assert property (reg_rd && reg_addr == RXC_OFS |=> (reg_rdata & ~RXC_RW_MASK) == 16'h0000)
      else $error("reserved bits not zero");

   pad_c: cover property (finish && fr_pad_reg && fr_crc_reg);
   pause_c: cover property ($fell(pause_active) ##[1:20] st_reg == TX_DATA);
   ucast_c: cover property (rx_end && live_now && !is_mcast ##1 rx_verdict.accept);
endmodule : hpq_ctrl

// *** rtl/hpq_pkg.sv ***
package hpq_pkg;
   // ***************************************************
   // register map (byte offsets on the 16-bit port)
   // ***************************************************
   localparam logic [2:0]  TXC_OFS     = 3'h0;
   localparam logic [2:0]  TXS_OFS     = 3'h2;
   localparam logic [2:0]  RXC_OFS     = 3'h4;
   localparam logic [15:0] REG_RST     = 16'h0000;
   localparam logic [15:0] TXC_RW_MASK = 16'h600F;
   localparam logic [15:0] RXC_RW_MASK = 16'h06FD;
   // transmit_control fields
   localparam int TXC_RUN  = 0;
   localparam int TXC_CRC  = 1;
   localparam int TXC_PAD  = 2;
   localparam int TXC_PGEN = 3;
   // receive_control fields
   localparam int RXC_RUN     = 0;
   localparam int RXC_HASH    = 2;
   localparam int RXC_CRCDROP = 3;
   localparam int RXC_PROMISC = 4;
   localparam int RXC_UCAST   = 5;
   localparam int RXC_MCAST   = 6;
   localparam int RXC_BCAST   = 7;
   localparam int RXC_BADCRC  = 9;
   localparam int RXC_PHONOR  = 10;
   // ***************************************************
   // frame and timing constants
   // ***************************************************
   localparam int TAG_W         = 6;
   localparam int CNT_W         = 7;
   localparam int MIN_FRAME_LEN = 64;
   localparam int FCS_LEN       = 4;
   localparam int PAD_LEN       = MIN_FRAME_LEN - FCS_LEN;
   localparam int ADDR_LEN      = 6;
   localparam int CLK_PERIOD_NS = 10;
   localparam int BIT_NS        = 10;
   localparam int QUANTUM_BITS  = 512;
   localparam int QUANTUM_CYC   = (QUANTUM_BITS * BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] CRC_POLY   = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT   = 32'hFFFFFFFF;
   localparam logic [47:0] BCAST_ADDR = 48'hFFFFFFFFFFFF;
   // ***************************************************
   // carriers and states
   // ***************************************************
   typedef struct packed {logic [7:0] data; logic last; logic [TAG_W-1:0] tag;} hpq_tx_in_t;
   typedef struct packed {logic [7:0] data; logic last;} hpq_tx_out_t;
   typedef struct packed {logic [7:0] data; logic last; logic crc_err;} hpq_rx_beat_t;
   typedef struct packed {logic accept; logic keep_crc;} hpq_verdict_t;
   typedef enum logic [3:0] {TX_IDLE = 4'h1, TX_DATA = 4'h2, TX_PAD = 4'h4, TX_FCS = 4'h8} hpq_tx_state_t;
endpackage : hpq_pkg

// *** tb/hpq_port_sink.sv ***
`timescale 1ns/1ps
// ************************************************
// port-side sink for transmit bytes
// ************************************************
module hpq_port_sink (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic stall,
   output logic      tx_out_ready
);
   initial tx_out_ready = 1'b0;
   // a real port is not always free, so random gaps come on top of commanded stalls
   always @(posedge core_clk) begin
      tx_out_ready <= rst_n && !stall && ($urandom % 4 != 0);
   end
endmodule : hpq_port_sink

// *** tb/host_port_queue_txrx_control_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module host_port_queue_txrx_control_test;
   import hpq_pkg::*;
   logic         core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic [2:0]   reg_addr = 3'h0;
   logic [15:0]  reg_wdata = 16'h0000, reg_rdata, rxc, rx_pause_quanta = 16'h0000;
   hpq_tx_in_t   tx_in = '0;
   hpq_tx_out_t  tx_out;
   hpq_rx_beat_t rx_beat = '0;
   hpq_verdict_t rx_verdict;
   logic         tx_in_valid = 1'b0, tx_in_ready, tx_out_valid, tx_out_ready, rx_beat_valid = 1'b0;
   logic         rx_hash_hit = 1'b0, rx_verdict_valid, rx_pause_rcvd = 1'b0, rx_fifo_at_thresh = 1'b0;
   logic         sw_fc_en = 1'b0, tx_pause_send, port_stall = 1'b0;
   logic [47:0]  station_addr = 48'h0000_0000_0000;
   logic [5:0]   last_tag;
   logic [15:0]  q_tx[$], q_rv[$], q_rd[$];
   logic [15:0]  exp_ff[4] = '{16'h600F, 16'h0000, 16'h06FD, 16'h0000};
   int           miscompares = 0, tests_run = 0;
   hpq_ctrl #(.BUF_DEPTH(2)) i_dut (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .tx_in, .tx_in_valid, .tx_in_ready, .tx_out, .tx_out_valid, .tx_out_ready, .rx_beat, .rx_beat_valid,
      .station_addr, .rx_hash_hit, .rx_verdict, .rx_verdict_valid, .rx_pause_rcvd, .rx_pause_quanta,
      .rx_fifo_at_thresh, .sw_fc_en, .tx_pause_send);
   hpq_port_sink i_sink (.core_clk(core_clk), .rst_n(rst_n), .stall(port_stall), .tx_out_ready(tx_out_ready));
   always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   task automatic pop_chk(input string nm, ref logic [15:0] q[$], input logic [15:0] g);
      logic [15:0] e;
      e = (q.size() != 0) ? q.pop_front() : 16'hDEAD;
      `CHK(nm, e, g)
   endtask : pop_chk
   // one-cycle strobe; for a read, d is the value expected back
   task automatic reg_io(input logic wr, input logic [2:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wr    <= wr;
      reg_rd    <= !wr;
      reg_wdata <= d;
      if (!wr) q_rd.push_back(d);
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask : reg_io
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      c = c ^ {24'h000000, b};
      repeat (8) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
      return c;
   endfunction : crc_byte
   // expectation is built before driving, so the watcher may see bytes at once
   task automatic send_tx(input int n, input logic pad, input logic crc);
      logic [31:0] c;
      logic [7:0]  b[$];
      c = 32'hFFFFFFFF;
      last_tag = 6'($urandom);
      for (int i = 0; i < n; i++) b.push_back(8'($urandom));
      for (int i = n; pad && i < 60; i++) b.push_back(8'h00);
      foreach (b[i]) c = crc_byte(c, b[i]);
      for (int i = 0; crc && i < 4; i++) b.push_back(~c[8*i +: 8]);
      foreach (b[i]) q_tx.push_back({7'h00, b[i], i == b.size() - 1});
      @(posedge core_clk);
      for (int i = 0; i < n; i++) begin
         tx_in       <= hpq_tx_in_t'{b[i], i == n - 1, last_tag};
         tx_in_valid <= 1'b1;
         do @(posedge core_clk); while (tx_in_ready !== 1'b1);
      end
      tx_in_valid <= 1'b0;
   endtask : send_tx
   task automatic drain();
      for (int k = 0; k < 3000 && q_tx.size() != 0; k++) @(posedge core_clk);
      `CHK("tx_drain", 0, q_tx.size())
      repeat (4) @(posedge core_clk);
   endtask : drain
   task automatic pulse_pause();
      @(posedge core_clk);
      rx_pause_rcvd   <= 1'b1;
      rx_pause_quanta <= 16'h0001;
      @(posedge core_clk);
      rx_pause_rcvd <= 1'b0;
   endtask : pulse_pause
   // kind: 0 broadcast, 1 multicast, 2 own station, 3 foreign unicast
   task automatic rx_frame(input logic [1:0] kind, input logic stop_mid);
      logic [47:0] da;
      logic        err, hit, mc, acc;
      int          n;
      n   = 8 + $urandom % 5;
      da  = {16'($urandom), $urandom};
      err = 1'($urandom);
      hit = 1'($urandom);
      if (kind == 2'd0) da = 48'hFFFFFFFFFFFF;
      if (kind == 2'd2) da = station_addr;
      if (kind[0]) da[40] = (kind == 2'd1);
      mc  = da[40];
      acc = (rxc[4] | (da == 48'hFFFFFFFFFFFF & rxc[7]) | (mc & rxc[6]) | (mc & rxc[2] & hit)
            | (!mc & rxc[5] & da == station_addr)) & (!err | rxc[9]);
      if (rxc[0]) q_rv.push_back({14'h0000, acc, !rxc[3]});
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         rx_beat       <= hpq_rx_beat_t'{i < 6 ? da[47 - 8*i -: 8] : 8'($urandom), i == n - 1, err};
         rx_beat_valid <= 1'b1;
         rx_hash_hit   <= hit;
         reg_wr        <= stop_mid && i == 3;
         reg_addr      <= RXC_OFS;
         reg_wdata     <= rxc & 16'hFFFE;
      end
      @(posedge core_clk);
      rx_beat_valid <= 1'b0;
      reg_wr        <= 1'b0;
   endtask : rx_frame
   // ************************************************
   // result watcher and watchdog
   // ************************************************
   always @(posedge core_clk) begin
      rd_d <= reg_rd;
      if (rd_d) pop_chk("reg_rdata", q_rd, reg_rdata);
      if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) pop_chk("tx_out", q_tx, {7'h00, tx_out});
      if (rx_verdict_valid === 1'b1) pop_chk("rx_verdict", q_rv, {14'h0000, rx_verdict});
   end
   initial begin
      repeat (40000) @(posedge core_clk);
      miscompares++;
      wrap_up();
   end
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      void'($urandom(32'h0984B8C5));
      station_addr = {16'($urandom), $urandom} & 48'hFEFF_FFFF_FFFF;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         reg_io(1'b0, 3'(2 * i), 16'h0000);
         reg_io(1'b1, 3'(2 * i), 16'hFFFF);
         reg_io(1'b0, 3'(2 * i), exp_ff[i]);
      end
      reg_io(1'b1, RXC_OFS, 16'h0000);
      // modes: plain, crc only, pad with crc; pad is never set without crc
      for (int m = 0; m < 4; m++) begin
         if (m == 2) continue;
         reg_io(1'b1, TXC_OFS, {13'h0000, m[1], m[0], 1'b1});
         send_tx(1, m[1], m[0]);
         send_tx(61, m[1], m[0]);
         drain();
         reg_io(1'b0, TXS_OFS, {10'h000, last_tag});
      end
      port_stall <= 1'b1;
      fork send_tx(5, 1'b1, 1'b1); join_none
      repeat (20) @(posedge core_clk);
      `CHK("tx_in_ready", 1'b0, tx_in_ready)
      port_stall <= 1'b0;
      drain();
      wait fork;
      reg_io(1'b1, TXC_OFS, 16'h0007);
      send_tx(1, 1'b1, 1'b1);
      reg_io(1'b1, TXC_OFS, 16'h0006);
      drain();
      send_tx(2, 1'b1, 1'b1);
      repeat (200) @(posedge core_clk);
      `CHK("tx_held", 64, q_tx.size())
      reg_io(1'b1, TXC_OFS, 16'h0007);
      drain();
      reg_io(1'b1, TXC_OFS, 16'h0001);
      reg_io(1'b1, RXC_OFS, 16'h0400);
      pulse_pause();
      send_tx(2, 1'b0, 1'b0);
      repeat (400) @(posedge core_clk);
      `CHK("tx_paused", 2, q_tx.size())
      drain();
      reg_io(1'b1, RXC_OFS, 16'h0000);
      pulse_pause();
      send_tx(2, 1'b0, 1'b0);
      repeat (30) @(posedge core_clk);
      `CHK("tx_unpaused", 0, q_tx.size())
      for (int i = 0; i < 8; i++) begin
         reg_io(1'b1, TXC_OFS, {12'h000, i[2], 3'b000});
         sw_fc_en          <= i[1];
         rx_fifo_at_thresh <= i[0];
         repeat (3) @(posedge core_clk);
         `CHK("tx_pause_send", i[2] & i[1] & i[0], tx_pause_send)
      end
      for (int i = 0; i < 32; i++) begin
         rxc = (16'($urandom) & 16'h06FC) | {15'h0000, i % 4 != 3};
         reg_io(1'b1, RXC_OFS, rxc);
         rx_frame(2'(i), i == 9);
      end
      repeat (10) @(posedge core_clk);
      `CHK("rx_pending", 0, q_rv.size())
      wrap_up();
   end
endmodule : host_port_queue_txrx_control_test
